//--- pkg/sdb_params.svh
/*
 Constants for the two-bank SDRAM link: timing in ns and in cycles, mode codes,
 command codes and widths.
 Assumes a 100 MHz clock on both ends.
*/
`ifndef SDB_PARAMS_SVH
`define SDB_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define SDB_CLK_NS         10
`define SDB_ROW_ACTIVE_TIME_MIN_NS    42
`define SDB_ROW_TO_COLUMN_DELAY_NS        20
`define SDB_TRP_NS         20
`define SDB_TWR_NS         10
`define SDB_ROW_ACTIVE_TIME_MIN_CYC   ((`SDB_ROW_ACTIVE_TIME_MIN_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_ROW_TO_COLUMN_DELAY_CYC       ((`SDB_ROW_TO_COLUMN_DELAY_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_TRP_CYC        ((`SDB_TRP_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)
`define SDB_TWR_CYC        ((`SDB_TWR_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)

// ****************************************
// Mode settings: read latency, burst length and codes, FIFO depth
// ****************************************
`define SDB_CAS_LAT        2
`define SDB_BURST_LEN      4
`define SDB_BURST_CODE     3'h2
`define SDB_BURST_FULL     3'h7
`define SDB_FIFO_DEPTH     4

// ****************************************
// Widths and command codes {ras_n, cas_n, we_n}
// ****************************************
`define SDB_DATA_W         16
`define SDB_COL_W          8
`define SDB_ROW_W          11
`define SDB_CMD_NOP        3'h7
`define SDB_CMD_OPEN       3'h3
`define SDB_CMD_CLOSE      3'h2
`define SDB_CMD_READ       3'h5
`define SDB_CMD_WRITE      3'h4

`endif

//--- pkg/sdb_pkg.sv
/*
 Types used by the controller end of the SDRAM link.
 Assumes sdb_params.svh for all numeric constants.
*/
package sdb_pkg;

    // ****************************************
    // Controller sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        SDB_C_IDLE,
        SDB_C_RCD,
        SDB_C_READ,
        SDB_C_WRITE,
        SDB_C_WAITCLOSE,
        SDB_C_RP
    } sdb_ctl_state_t;

endpackage

//--- pkg/sdb_if.sv
/*
 Link between the memory controller and the SDRAM.
 Assumes one shared clock; the shared data wire is resolved here from the two
 drivers' active-low enables.
*/
`timescale 1ns/1ps

interface sdb_if;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bank_select_bit;
    logic        precharge_select_bit;
    logic [9:0]  addr;
    logic        low_byte_mask;
    logic        high_byte_mask;
    logic [15:0] dq_ctl;
    logic        dq_ctl_oe_n;
    logic [15:0] dq_dev;
    logic [1:0]  dq_dev_oe_n;
    logic [15:0] dq_bus;

    // ****************************************
    // Wire resolution, per byte lane
    // ****************************************
    assign dq_bus[7:0]  = !dq_dev_oe_n[0] ? dq_dev[7:0]  : (!dq_ctl_oe_n ? dq_ctl[7:0]  : 8'h00);
    assign dq_bus[15:8] = !dq_dev_oe_n[1] ? dq_dev[15:8] : (!dq_ctl_oe_n ? dq_ctl[15:8] : 8'h00);

    modport dev (
        input  cs_n, ras_n, cas_n, we_n, bank_select_bit, precharge_select_bit, addr,
        input  low_byte_mask, high_byte_mask, dq_bus,
        output dq_dev, dq_dev_oe_n
    );

    modport ctl (
        output cs_n, ras_n, cas_n, we_n, bank_select_bit, precharge_select_bit, addr,
        output low_byte_mask, high_byte_mask, dq_ctl, dq_ctl_oe_n,
        input  dq_bus
    );
endinterface

//--- hdl/sdb_sdram_end.sv
/*
 SDRAM end of the link: two banks, close commands, burst reads and writes with
 interruption, byte masks and data turnaround.
 Assumes the controller on the same clock obeys the timing it owns; mode settings
 are static inputs.
*/
`timescale 1ns/1ps
`include "sdb_params.svh"

module sdb_sdram_end (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic [1:0] cas_lat_in,
    input  wire logic [2:0] burst_code_in,
    input  wire logic       interleave_in,
    sdb_if.dev              link
);

    // ****************************************
    // Storage
    // ****************************************
    logic [`SDB_DATA_W-1:0] mem_r [0:(2**(1+`SDB_ROW_W+`SDB_COL_W))-1];

    // ****************************************
    // Command decode
    // ****************************************
    wire       cmd_sel   = ~link.cs_n;
    wire       cmd_open  = cmd_sel & ~link.ras_n &  link.cas_n &  link.we_n;
    wire       cmd_close = cmd_sel & ~link.ras_n &  link.cas_n & ~link.we_n;
    wire       cmd_read  = cmd_sel &  link.ras_n & ~link.cas_n &  link.we_n;
    wire       cmd_write = cmd_sel &  link.ras_n & ~link.cas_n & ~link.we_n;
    wire       cmd_bank  = link.bank_select_bit;
    wire       cmd_psel  = link.precharge_select_bit;
    wire [7:0] cmd_col   = link.addr[7:0];
    wire [1:0] lane_mask = {link.high_byte_mask, link.low_byte_mask};

    // ****************************************
    // Bank state
    // ****************************************
    logic [1:0]              bank_active_r;
    logic [`SDB_ROW_W-1:0]   open_row_r [0:1];
    logic [1:0]              close_hit;
    logic [1:0]              ap_done;

    // ****************************************
    // Burst engine state
    // ****************************************
    logic       brd_r;
    logic       bwr_r;
    logic       bbank_r;
    logic       bap_r;
    logic [7:0] bstart_r;
    logic [7:0] bcnt_r;

    // ****************************************
    // Burst geometry
    // ****************************************
    wire       full_page = (burst_code_in == `SDB_BURST_FULL);
    wire [7:0] len_mask  = full_page              ? 8'hFF :
                           (burst_code_in == 3'h3) ? 8'h07 :
                           (burst_code_in == 3'h2) ? 8'h03 :
                           (burst_code_in == 3'h1) ? 8'h01 : 8'h00;
    wire [7:0] seq_sum   = bstart_r + bcnt_r;
    // Sequential wraps inside the burst window; full page wraps past the last column to 0
    wire [7:0] cur_col   = interleave_in ? (bstart_r ^ (bcnt_r & len_mask))
                                         : ((bstart_r & ~len_mask) | (seq_sum & len_mask));

    // ****************************************
    // Command effect, with interruption
    // ****************************************
    wire       col_ok     = bank_active_r[cmd_bank];
    wire       rd_go      = cmd_read & col_ok;
    wire       wr_go      = cmd_write & col_ok;
    wire       new_burst  = rd_go | wr_go;
    wire       cut        = close_hit[bbank_r];
    wire       run_rd     = rd_go | (~new_burst & brd_r & ~cut);
    // A read command to an open bank ends any write burst in progress
    wire       run_wr     = wr_go | (~new_burst & bwr_r & ~cut);
    wire       step_bank  = new_burst ? cmd_bank : bbank_r;
    wire [7:0] step_col   = new_burst ? cmd_col : cur_col;
    wire [7:0] step_cnt   = new_burst ? 8'h00 : bcnt_r;
    wire       step_last  = ~full_page & (step_cnt == len_mask);
    // Full page bursts ignore the auto-precharge request
    wire       step_ap    = new_burst ? (cmd_psel & ~full_page) : bap_r;
    wire       step_run   = run_rd | run_wr;
    wire [`SDB_ROW_W+`SDB_COL_W:0] step_addr = {step_bank, open_row_r[step_bank], step_col};

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bank
            assign close_hit[gb] = cmd_close & (cmd_psel | (cmd_bank == 1'(gb)));
            assign ap_done[gb]   = step_run & step_last & step_ap & (step_bank == 1'(gb));

            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    bank_active_r[gb] <= 1'b0;
                end else if (close_hit[gb] | ap_done[gb]) begin
                    bank_active_r[gb] <= 1'b0;
                end else if (cmd_open & (cmd_bank == 1'(gb))) begin
                    bank_active_r[gb] <= 1'b1;
                end
            end

            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    open_row_r[gb] <= '0;
                end else if (cmd_open & (cmd_bank == 1'(gb)) & ~bank_active_r[gb]) begin
                    open_row_r[gb] <= {cmd_psel, link.addr};
                end
            end
        end
    endgenerate

    // ****************************************
    // Burst registers
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            brd_r    <= 1'b0;
            bwr_r    <= 1'b0;
            bbank_r  <= 1'b0;
            bap_r    <= 1'b0;
            bstart_r <= 8'h00;
            bcnt_r   <= 8'h00;
        end else begin
            brd_r   <= run_rd & ~step_last;
            bwr_r   <= run_wr & ~step_last;
            bbank_r <= step_bank;
            bap_r   <= step_ap;
            bcnt_r  <= step_cnt + 8'h01;
            if (new_burst) begin
                bstart_r <= cmd_col;
            end
        end
    end

    // ****************************************
    // Write path: word taken on the command edge and each later edge
    // ****************************************
    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (run_wr & ~lane_mask[i]) begin
                mem_r[step_addr][8*i +: 8] <= link.dq_bus[8*i +: 8];
            end
        end
    end

    // ****************************************
    // Read pipeline for the read latency
    // ****************************************
    logic [1:0]             pvld_r;
    logic [`SDB_DATA_W-1:0] pdat_r [0:1];
    logic [1:0]             mask_d1_r;
    logic [`SDB_DATA_W-1:0] dout_r;
    logic [1:0]             dout_oe_n_r;
    wire  [`SDB_DATA_W-1:0] fetch_word = mem_r[step_addr];

    generate
        for (gb = 0; gb < 2; gb++) begin : g_pipe
            wire                   in_vld = (gb == 0) ? run_rd     : pvld_r[0];
            wire [`SDB_DATA_W-1:0] in_dat = (gb == 0) ? fetch_word : pdat_r[0];
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    pvld_r[gb] <= 1'b0;
                    pdat_r[gb] <= '0;
                end else begin
                    pvld_r[gb] <= in_vld;
                    pdat_r[gb] <= in_dat;
                end
            end
        end
    endgenerate

    // The output flop is the last stage, so latency one loads it on the command edge
    wire                   out_vld_nxt = (cas_lat_in == 2'h1) ? run_rd     :
                                         (cas_lat_in == 2'h2) ? pvld_r[0]  : pvld_r[1];
    wire [`SDB_DATA_W-1:0] dout_nxt    = (cas_lat_in == 2'h1) ? fetch_word :
                                         (cas_lat_in == 2'h2) ? pdat_r[0]  : pdat_r[1];

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_d1_r   <= 2'h3;
            dout_r      <= '0;
            dout_oe_n_r <= 2'h3;
        end else begin
            mask_d1_r   <= lane_mask;
            dout_r      <= dout_nxt;
            // Mask taken one edge before the flop loads, two before the word is sampled
            dout_oe_n_r <= ~({2{out_vld_nxt}} & ~mask_d1_r);
        end
    end

    assign link.dq_dev      = dout_r;
    assign link.dq_dev_oe_n = dout_oe_n_r;

endmodule // sdb_sdram_end

//--- hdl/sdb_ctrl_end.sv
/*
 Controller end of the SDRAM link: a write-data FIFO and a closed-page sequencer
 that opens, reads or writes one burst, then closes the bank.
 Assumes the SDRAM is set to the header's read latency and burst length.
*/
`timescale 1ns/1ps
`include "sdb_params.svh"

module sdb_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input  wire logic                 mclk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 in_valid_in,
    output logic                      in_ready_out,
    input  wire logic [W-1:0]         in_data_in,
    output logic                      out_valid_out,
    input  wire logic                 out_ready_in,
    output logic [W-1:0]              out_data_out,
    output logic [$clog2(D):0]        level_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0] buf_r [0:D-1];
    logic [AW:0]  wr_r;
    logic [AW:0]  rd_r;
    wire          push = in_valid_in & in_ready_out;
    wire          pop  = out_valid_out & out_ready_in;

    assign level_out     = wr_r - rd_r;
    assign in_ready_out  = (level_out != D[AW:0]);
    assign out_valid_out = (level_out != '0);
    assign out_data_out  = buf_r[rd_r[AW-1:0]];

    always_ff @(posedge mclk_in) begin
        if (push) begin
            buf_r[wr_r[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
        end
    end
endmodule // sdb_fifo

module sdb_ctrl_end (
    input  wire logic                   mclk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   req_valid_in,
    output logic                        req_ready_out,
    input  wire logic                   req_write_in,
    input  wire logic                   req_bank_in,
    input  wire logic [`SDB_ROW_W-1:0]  req_row_in,
    input  wire logic [`SDB_COL_W-1:0]  req_col_in,
    input  wire logic                   wdata_valid_in,
    output logic                        wdata_ready_out,
    input  wire logic [`SDB_DATA_W-1:0] wdata_in,
    output logic [`SDB_DATA_W-1:0]      rdata_out,
    output logic                        rdata_valid_out,
    sdb_if.ctl                          link
);
    sdb_pkg::sdb_ctl_state_t state_r;
    logic [2:0]              cmd_r;
    logic                    bank_r;
    logic                    write_r;
    logic [`SDB_COL_W-1:0]   col_r;
    logic [9:0]              addr_r;
    logic                    psel_r;
    logic [7:0]              tm_r;
    logic [7:0]              ras_r;
    logic [15:0]             dq_r;
    logic                    dq_oe_n_r;
    logic                    mask_r;
    logic                    fifo_valid;
    logic [`SDB_DATA_W-1:0]  fifo_data;
    logic [2:0]              fifo_level;

    wire idle   = (state_r == sdb_pkg::SDB_C_IDLE);
    wire accept = req_valid_in & req_ready_out;
    wire go_col = (state_r == sdb_pkg::SDB_C_RCD) & (tm_r == 8'h00);
    wire pop    = (go_col & write_r) |
                  ((state_r == sdb_pkg::SDB_C_WRITE) & (tm_r < 8'(`SDB_BURST_LEN)));
    wire capture = (state_r == sdb_pkg::SDB_C_READ) & (tm_r >= 8'(`SDB_CAS_LAT));
    wire ras_ok = (ras_r >= 8'(`SDB_ROW_ACTIVE_TIME_MIN_CYC));

    assign req_ready_out = idle & (~req_write_in | (fifo_level >= 3'(`SDB_BURST_LEN)));

    sdb_fifo #(.W(`SDB_DATA_W), .D(`SDB_FIFO_DEPTH)) u_wfifo (
        .mclk_in      (mclk_in),
        .reset_n_in   (reset_n_in),
        .in_valid_in  (wdata_valid_in),
        .in_ready_out (wdata_ready_out),
        .in_data_in   (wdata_in),
        .out_valid_out(fifo_valid),
        .out_ready_in (pop & fifo_valid),
        .out_data_out (fifo_data),
        .level_out    (fifo_level)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r   <= sdb_pkg::SDB_C_IDLE;
            cmd_r     <= `SDB_CMD_NOP;
            bank_r    <= 1'b0;
            write_r   <= 1'b0;
            col_r     <= '0;
            addr_r    <= '0;
            psel_r    <= 1'b0;
            tm_r      <= 8'h00;
            ras_r     <= 8'h00;
            dq_r      <= '0;
            dq_oe_n_r <= 1'b1;
            mask_r    <= 1'b0;
            rdata_out <= '0;
            rdata_valid_out <= 1'b0;
        end else begin
            cmd_r <= `SDB_CMD_NOP;
            rdata_valid_out <= capture;
            if (capture) begin
                rdata_out <= link.dq_bus;
            end
            if (ras_r != 8'hFF) begin
                ras_r <= ras_r + 8'h01;
            end
            case (state_r)
                sdb_pkg::SDB_C_IDLE: begin
                    mask_r <= 1'b0;
                    if (accept) begin
                        cmd_r   <= `SDB_CMD_OPEN;
                        bank_r  <= req_bank_in;
                        write_r <= req_write_in;
                        col_r   <= req_col_in;
                        addr_r  <= req_row_in[9:0];
                        psel_r  <= req_row_in[10];
                        ras_r   <= 8'h00;
                        tm_r    <= 8'(`SDB_ROW_TO_COLUMN_DELAY_CYC - 1);
                        state_r <= sdb_pkg::SDB_C_RCD;
                    end
                end
                sdb_pkg::SDB_C_RCD: begin
                    if (go_col) begin
                        cmd_r   <= write_r ? `SDB_CMD_WRITE : `SDB_CMD_READ;
                        addr_r  <= {2'b00, col_r};
                        // No auto-precharge: the sequencer closes the bank itself
                        psel_r  <= 1'b0;
                        if (write_r) begin
                            dq_r      <= fifo_data;
                            dq_oe_n_r <= 1'b0;
                            tm_r      <= 8'h01;
                            state_r   <= sdb_pkg::SDB_C_WRITE;
                        end else begin
                            tm_r    <= 8'h00;
                            state_r <= sdb_pkg::SDB_C_READ;
                        end
                    end else begin
                        tm_r <= tm_r - 8'h01;
                    end
                end
                sdb_pkg::SDB_C_READ: begin
                    tm_r <= tm_r + 8'h01;
                    // Whole burst is taken back first, so no write ever meets read data
                    if (tm_r == 8'(`SDB_CAS_LAT + `SDB_BURST_LEN - 1)) begin
                        tm_r    <= 8'h00;
                        state_r <= sdb_pkg::SDB_C_WAITCLOSE;
                    end
                end
                sdb_pkg::SDB_C_WRITE: begin
                    if (pop) begin
                        dq_r <= fifo_data;
                        tm_r <= tm_r + 8'h01;
                    end else begin
                        dq_oe_n_r <= 1'b1;
                        mask_r    <= 1'b1;
                        tm_r      <= 8'(`SDB_TWR_CYC - 1);
                        state_r   <= sdb_pkg::SDB_C_WAITCLOSE;
                    end
                end
                sdb_pkg::SDB_C_WAITCLOSE: begin
                    if ((tm_r == 8'h00) & ras_ok) begin
                        cmd_r   <= `SDB_CMD_CLOSE;
                        psel_r  <= 1'b0;
                        tm_r    <= 8'(`SDB_TRP_CYC - 1);
                        state_r <= sdb_pkg::SDB_C_RP;
                    end else if (tm_r != 8'h00) begin
                        tm_r <= tm_r - 8'h01;
                    end
                end
                sdb_pkg::SDB_C_RP: begin
                    if (tm_r == 8'h00) begin
                        state_r <= sdb_pkg::SDB_C_IDLE;
                    end else begin
                        tm_r <= tm_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= sdb_pkg::SDB_C_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n                 = 1'b0;
    assign link.ras_n                = cmd_r[2];
    assign link.cas_n                = cmd_r[1];
    assign link.we_n                 = cmd_r[0];
    assign link.bank_select_bit      = bank_r;
    assign link.precharge_select_bit = psel_r;
    assign link.addr                 = addr_r;
    assign link.low_byte_mask        = mask_r;
    assign link.high_byte_mask       = mask_r;
    assign link.dq_ctl               = dq_r;
    assign link.dq_ctl_oe_n          = dq_oe_n_r;

endmodule // sdb_ctrl_end

//--- verification/sdb_link_assertions.sv
/*
 Checker on the SDRAM link signals.
 Assumes traffic from the controller end only, read latency 2 and burst length 4.
*/
`timescale 1ns/1ps
`include "sdb_params.svh"

module sdb_link_assertions (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       low_byte_mask,
    input  wire logic       high_byte_mask,
    input  wire logic       dq_ctl_oe_n,
    input  wire logic [1:0] dq_dev_oe_n
);
    // ****************
    // Command decode and row-active age
    // ****************
    wire  [2:0] cmd = cs_n ? `SDB_CMD_NOP : {ras_n, cas_n, we_n};
    logic [3:0] act_r;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) act_r <= 4'h0;
        else if (cmd == `SDB_CMD_OPEN) act_r <= 4'h1;
        else if (act_r != 4'hF) act_r <= act_r + 4'h1;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    AST_RD_LAT: assert property (cmd == `SDB_CMD_READ |-> ##2 (dq_dev_oe_n == 2'h0) [*4])
        else $error("read words not driven in their window");
    AST_RD_REL: assert property (cmd == `SDB_CMD_READ |-> ##6 dq_dev_oe_n == 2'h3)
        else $error("data pins not released after read burst");
    AST_RD_MASK: assert property (dq_dev_oe_n != 2'h3 |->
        dq_dev_oe_n == {$past(high_byte_mask, 2), $past(low_byte_mask, 2)})
        else $error("read lane enable does not follow mask");
    AST_NO_CLASH: assert property (!(dq_ctl_oe_n == 1'b0 && dq_dev_oe_n != 2'h3))
        else $error("both ends drive data");
    AST_RCD: assert property (cmd == `SDB_CMD_OPEN |=> cmd != `SDB_CMD_READ && cmd != `SDB_CMD_WRITE)
        else $error("column command too soon after open");
    AST_WR_DATA: assert property (cmd == `SDB_CMD_WRITE |-> (dq_ctl_oe_n == 1'b0) [*4] ##1 dq_ctl_oe_n)
        else $error("write data not driven for the burst");
    AST_WR_MASK: assert property (cmd == `SDB_CMD_WRITE |=>
        (cmd != `SDB_CMD_CLOSE) [*3] ##1 (low_byte_mask && high_byte_mask))
        else $error("close too early or data not masked after write");
    AST_ROW_ACTIVE_TIME: assert property (cmd == `SDB_CMD_CLOSE |-> act_r >= `SDB_ROW_ACTIVE_TIME_MIN_CYC)
        else $error("bank closed before minimum active time");
endmodule // sdb_link_assertions

//--- verification/testbench.sv
/*
 Testbench: controller end and SDRAM end joined by the link interface.
 Assumes the link interface has no ports and both ends share one clock.
*/
`timescale 1ns/1ps

module testbench;
    typedef struct packed {logic bank; logic [10:0] row; logic [7:0] col; logic [15:0] base;} sdb_row_t;
    localparam sdb_row_t ROWS [4] = '{'{1'b0, 11'h000, 8'h00, 16'h1100}, '{1'b1, 11'h000, 8'h00, 16'h2200},
                                      '{1'b0, 11'h7FF, 8'hFC, 16'h3300}, '{1'b1, 11'h123, 8'h40, 16'hA5A0}};
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        req_valid_in = 1'b0;
    logic        req_write_in = 1'b0;
    logic        req_bank_in = 1'b0;
    logic [10:0] req_row_in = 11'h000;
    logic [7:0]  req_col_in = 8'h00;
    logic        wdata_valid_in = 1'b0;
    logic [15:0] wdata_in = 16'h0000;
    logic        interleave_in = 1'b0;
    logic        req_ready_out, wdata_ready_out, rdata_valid_out;
    logic [15:0] rdata_out;
    int          error_cnt = 0, checks = 0, cyc = 0;

    sdb_if sdb_if_i ();
    sdb_sdram_end sdb_sdram_end_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cas_lat_in(2'h2),
        .burst_code_in(3'h2), .interleave_in(interleave_in), .link(sdb_if_i));
    sdb_ctrl_end sdb_ctrl_end_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
        .req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_bank_in(req_bank_in),
        .req_row_in(req_row_in), .req_col_in(req_col_in), .wdata_valid_in(wdata_valid_in),
        .wdata_ready_out(wdata_ready_out), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .rdata_valid_out(rdata_valid_out), .link(sdb_if_i));
    sdb_link_assertions sdb_link_assertions_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .cs_n(sdb_if_i.cs_n), .ras_n(sdb_if_i.ras_n), .cas_n(sdb_if_i.cas_n), .we_n(sdb_if_i.we_n),
        .low_byte_mask(sdb_if_i.low_byte_mask), .high_byte_mask(sdb_if_i.high_byte_mask),
        .dq_ctl_oe_n(sdb_if_i.dq_ctl_oe_n), .dq_dev_oe_n(sdb_if_i.dq_dev_oe_n));

    // ****************
    // Clock, timeout and shared tasks
    // ****************
    always #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Leaves valid high so back-to-back words need no extra cycle
    task automatic push(input logic [15:0] w);
        wdata_in = w;
        wdata_valid_in = 1'b1;
        while (wdata_ready_out !== 1'b1) @(negedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic req(input logic wr, input sdb_row_t r);
        {req_write_in, req_bank_in, req_row_in, req_col_in} = {wr, r.bank, r.row, r.col};
        req_valid_in = 1'b1;
        while (req_ready_out !== 1'b1) @(negedge mclk_in);
        @(negedge mclk_in);
        req_valid_in = 1'b0;
    endtask
    // Word j is expected from burst index j xor x
    task automatic rd(input sdb_row_t r, input logic [1:0] x);
        @(negedge mclk_in);
        req(1'b0, r);
        for (int j = 0; j < 4; j++) begin
            for (int n = 0; n < 40 && rdata_valid_out !== 1'b1; n++) @(negedge mclk_in);
            chk(rdata_out, r.base + 16'(2'(j) ^ x));
            @(negedge mclk_in);
        end
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        sdb_row_t r;
        repeat (4) @(negedge mclk_in);
        reset_n_in = 1'b1;
        chk({15'h0, rdata_valid_out}, 16'h0000);
        chk({15'h0, req_ready_out}, 16'h0001);
        foreach (ROWS[i]) begin
            for (int j = 0; j < 4; j++) push(ROWS[i].base + 16'(j));
            wdata_valid_in = 1'b0;
            chk({15'h0, wdata_ready_out}, 16'h0000);
            req(1'b1, ROWS[i]);
            rd(ROWS[i], 2'h0);
        end
        rd(ROWS[0], 2'h0);
        r = ROWS[2];
        r.col = 8'hFE;
        rd(r, 2'h2);
        interleave_in = 1'b1;
        r = ROWS[3];
        r.col = 8'h41;
        rd(r, 2'h1);
        // Reset in the middle of a read: pins released, banks idle, memory kept
        req(1'b0, ROWS[1]);
        repeat (3) @(negedge mclk_in);
        reset_n_in = 1'b0;
        @(negedge mclk_in);
        reset_n_in = 1'b1;
        chk({15'h0, rdata_valid_out}, 16'h0000);
        chk({14'h0, sdb_if_i.dq_dev_oe_n}, 16'h0003);
        chk({15'h0, req_ready_out}, 16'h0001);
        rd(ROWS[1], 2'h0);
        wrap_up();
    end
endmodule // testbench
